// >>> common/boot_key_pkg.sv
package boot_key_pkg;

	// Clock and instruction cycle timing.
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned INSTR_CYCLE_NS = 1000;
	localparam int unsigned INSTR_DIV_CYCLES = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] INSTR_DIV_LAST = 5'(INSTR_DIV_CYCLES - 1);
	localparam logic [3:0] KEY_WINDOW_CYCLES = 4'h8;
	localparam logic [1:0] FORCED_HOLD_CYCLES = 2'h3;

	// Key pattern on bits 7..2 of a key write.
	localparam logic [5:0] KEY_PATTERN = 6'h26;

	// Register byte offsets.
	localparam logic [7:0] OFS_PULSE_TIMING = 8'h00;
	localparam logic [7:0] OFS_BOOT_KEY = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_CONTROL = 8'h0c;

	// Reset value and write mask of the pulse timing register.
	localparam logic [7:0] PULSE_TIMING_RST = 8'h07;
	localparam logic [6:0] PULSE_TIMING_MASK = 7'h7f;

	// Status field positions.
	localparam int unsigned ST_KEY_SET = 0;
	localparam int unsigned ST_FORCED_PIN = 1;
	localparam int unsigned ST_IN_BOOT = 2;
	localparam int unsigned ST_SECURITY = 3;
	localparam int unsigned ST_FLEX = 4;
	localparam int unsigned ST_CODE_LISTED = 5;
	localparam int unsigned ST_FORCED_ENTRY = 6;
	localparam int unsigned ST_KEY_LEFT_LSB = 8;

	// Control field positions.
	localparam int unsigned CT_EXIT = 0;

	// Listed pulse timing codes, lowest clock range first.
	localparam logic [7:0] TIMING_CODES [19] = '{
		8'h07, 8'h08, 8'h0b, 8'h0f, 8'h11, 8'h17, 8'h1d, 8'h27, 8'h2f, 8'h3f,
		8'h47, 8'h48, 8'h4b, 8'h4f, 8'h54, 8'h5b, 8'h63, 8'h6f, 8'h7b};

	// Program source of the core.
	typedef enum logic [1:0] {
		EXEC_FLASH = 2'b00,
		EXEC_BOOT = 2'b01,
		EXEC_FORCED = 2'b10
	} exec_e;

	// True when a code belongs to one of the listed clock ranges.
	function automatic logic timing_code_listed(input logic [7:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 19; i++)
		begin
			if (TIMING_CODES[i] == code)
			begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

endpackage

// >>> design/key_window_timer.sv
`timescale 1ns/1ns
module key_window_timer
	import boot_key_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// Control.
	input wire logic instr_tick_in,
	input wire logic key_load_in,
	input wire logic freeze_in,
	// Key state.
	output logic key_set_out,
	output logic [3:0] cycles_left_out
);

	typedef struct packed {
		logic active;
		logic [3:0] left;
	} timer_s;

	timer_s s_r;
	timer_s s_nxt;

	// Outside reset a load always wins, so a second match restarts the window in full.
	always_comb
	begin
		s_nxt = s_r;
		if (sys_rst_in)
		begin
			s_nxt = '0;
		end
		else if (key_load_in)
		begin
			s_nxt.active = 1'b1;
			s_nxt.left = KEY_WINDOW_CYCLES;
		end
		// Only a breakpoint freezes; interrupts are not seen here at all.
		else if (s_r.active && instr_tick_in && !freeze_in)
		begin
			if (s_r.left == 4'h1)
			begin
				s_nxt.active = 1'b0;
				s_nxt.left = 4'h0;
			end
			else
			begin
				s_nxt.left = s_r.left - 4'h1;
			end
		end
	end

	// State register.
	always_ff @(posedge ref_clk_in)
	begin
		s_r <= s_nxt;
	end

	assign key_set_out = s_r.active;
	assign cycles_left_out = s_r.left;

	// Last tick of the window clears the key.
	a_key_window_end: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		s_r.active && s_r.left == 4'h1 && instr_tick_in && !freeze_in && !key_load_in |=> !s_r.active)
		else $error("key did not expire after its last cycle");

	// A frozen counter keeps its count.
	a_key_freeze_hold: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		s_r.active && freeze_in && !key_load_in |=> $stable(s_r.left) && s_r.active)
		else $error("key counter moved during breakpoint");

	// A load always restarts the full window.
	a_key_restart_full: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		key_load_in |=> s_r.active && s_r.left == KEY_WINDOW_CYCLES)
		else $error("key load did not restart full window");

endmodule

// >>> design/boot_entry_ctrl.sv
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ns
module boot_entry_ctrl
	import boot_key_pkg::*;
(
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// Wishbone slave.
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// Core instruction events.
	input wire logic jump_to_boot_instr_in,
	input wire logic return_to_flash_instr_in,
	input wire logic emulation_mode_in,
	input wire logic breakpoint_in,
	// Option bits and erase events.
	input wire logic flash_execute_opt_in,
	input wire logic security_opt_in,
	input wire logic security_program_in,
	input wire logic mass_erase_in,
	input wire logic user_isp_sec_clear_in,
	// Forced boot pin.
	input wire logic forced_boot_pin_in,
	input wire logic forced_boot_hv_in,
	// Serial clock pin.
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe_out,
	// Program source and events.
	output logic fetch_from_boot_out,
	output logic boot_jump_out,
	output logic flash_jump_out,
	output logic flash_return_out,
	output logic exit_reset_req_out,
	output logic [7:0] flash_pulse_timing_out,
	output logic security_bit_out
);

	typedef struct packed {
		logic ack;
		logic [31:0] rd_data;
		logic [7:0] pulse_timing;
		exec_e exec;
		logic boot_sel;
		logic [4:0] div;
		logic tick;
		logic sclk;
		logic sclk_oe;
		logic security;
		logic boot_jump;
		logic flash_jump;
		logic flash_ret;
		logic exit_req;
		logic key_load;
		logic forced_entry;
		logic [1:0] hv_hold;
	} ctrl_s;

	ctrl_s s_r;
	ctrl_s s_nxt;

	logic key_set;
	logic [3:0] key_left;
	logic bus_take;
	logic wr_low;
	logic key_match;
	logic pin_level;

	// The key window counts instruction cycles, not bus clocks.
	key_window_timer u_key_timer (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.instr_tick_in(s_r.tick),
		.key_load_in(s_r.key_load),
		.freeze_in(emulation_mode_in && breakpoint_in),
		.key_set_out(key_set),
		.cycles_left_out(key_left)
	);

	// A request is taken at the edge where the registered ack is high, so each
	// write acts exactly once, on the edge the master sees the answer.
	assign bus_take = wb_cyc_in && wb_stb_in && s_r.ack;
	assign wr_low = bus_take && wb_we_in && wb_sel_in[0];
	assign key_match = wb_dat_in[7:2] == KEY_PATTERN;
	// The pin reads as one whenever the high voltage is present.
	assign pin_level = forced_boot_pin_in || forced_boot_hv_in;

	// Next-state logic for the whole block.
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.boot_jump = 1'b0;
		s_nxt.flash_jump = 1'b0;
		s_nxt.flash_ret = 1'b0;
		s_nxt.exit_req = 1'b0;
		s_nxt.key_load = 1'b0;
		s_nxt.tick = 1'b0;
		if (sys_rst_in)
		begin
			s_nxt = '0;
			s_nxt.pulse_timing = PULSE_TIMING_RST;
			// Option bits are only read, never written back.
			s_nxt.security = security_opt_in;
			if (forced_boot_hv_in)
			begin
				// The flex bit is bypassed entirely.
				s_nxt.exec = EXEC_FORCED;
				s_nxt.forced_entry = 1'b1;
				s_nxt.hv_hold = FORCED_HOLD_CYCLES;
			end
			else if (flash_execute_opt_in)
			begin
				s_nxt.exec = EXEC_FLASH;
			end
			else
			begin
				s_nxt.exec = EXEC_BOOT;
			end
			s_nxt.boot_sel = s_nxt.exec != EXEC_FLASH;
		end
		else
		begin
			// Instruction cycle divider.
			if (s_r.div == INSTR_DIV_LAST)
			begin
				s_nxt.div = 5'h0;
				s_nxt.tick = 1'b1;
			end
			else
			begin
				s_nxt.div = s_r.div + 5'h1;
			end

			// Countdown of the post-reset hold of the high voltage.
			if (s_r.tick && s_r.hv_hold != 2'h0)
			begin
				s_nxt.hv_hold = s_r.hv_hold - 2'h1;
			end

			// Load clock on the serial pin while the high voltage is present.
			// It may fight an external shift clock; that clash is the user's.
			s_nxt.sclk_oe = forced_boot_hv_in;
			if (!forced_boot_hv_in)
			begin
				s_nxt.sclk = 1'b0;
			end
			else if (s_r.tick)
			begin
				s_nxt.sclk = !s_r.sclk;
			end

			// Security: a program event sets, only erases clear, set wins.
			if (security_program_in)
			begin
				s_nxt.security = 1'b1;
			end
			else if (mass_erase_in || user_isp_sec_clear_in)
			begin
				s_nxt.security = 1'b0;
			end

			// Wishbone answer: one cycle of ack, then a dead cycle.
			s_nxt.ack = wb_cyc_in && wb_stb_in && !s_r.ack;
			s_nxt.rd_data = 32'h0;
			if (wb_cyc_in && wb_stb_in && !s_r.ack && !wb_we_in)
			begin
				unique case (wb_adr_in)
					OFS_PULSE_TIMING:
					begin
						s_nxt.rd_data[7:0] = {1'b0, s_r.pulse_timing[6:0]};
					end
					OFS_STATUS:
					begin
						s_nxt.rd_data[ST_KEY_SET] = key_set;
						s_nxt.rd_data[ST_FORCED_PIN] = pin_level;
						s_nxt.rd_data[ST_IN_BOOT] = s_r.boot_sel;
						s_nxt.rd_data[ST_SECURITY] = s_r.security;
						s_nxt.rd_data[ST_FLEX] = flash_execute_opt_in;
						s_nxt.rd_data[ST_CODE_LISTED] = timing_code_listed(s_r.pulse_timing);
						s_nxt.rd_data[ST_FORCED_ENTRY] = s_r.forced_entry;
						s_nxt.rd_data[ST_KEY_LEFT_LSB +: 4] = key_left;
					end
					default:
					begin
						s_nxt.rd_data = 32'h0;
					end
				endcase
			end

			// Register writes.
			if (wr_low)
			begin
				unique case (wb_adr_in)
					OFS_PULSE_TIMING:
					begin
						s_nxt.pulse_timing = {1'b0, wb_dat_in[6:0] & PULSE_TIMING_MASK};
					end
					OFS_BOOT_KEY:
					begin
						// A mismatch simply leaves the key as it is.
						s_nxt.key_load = key_match;
					end
					OFS_CONTROL:
					begin
						s_nxt.exit_req = wb_dat_in[CT_EXIT];
					end
					default:
					begin
						s_nxt.exit_req = 1'b0;
					end
				endcase
			end

			// Program source changes from core instruction events.
			unique case (s_r.exec)
				EXEC_FLASH:
				begin
					if (jump_to_boot_instr_in)
					begin
						if (key_set)
						begin
							s_nxt.exec = EXEC_BOOT;
							s_nxt.boot_jump = 1'b1;
						end
						else
						begin
							s_nxt.flash_jump = 1'b1;
						end
					end
				end
				EXEC_BOOT, EXEC_FORCED:
				begin
					// Flash stays unfetched while boot code programs it.
					if (return_to_flash_instr_in)
					begin
						s_nxt.exec = EXEC_FLASH;
						s_nxt.flash_ret = 1'b1;
					end
				end
				default:
				begin
					s_nxt.exec = EXEC_FLASH;
				end
			endcase
			s_nxt.boot_sel = s_nxt.exec != EXEC_FLASH;
		end
	end

	// State register.
	always_ff @(posedge ref_clk_in)
	begin
		s_r <= s_nxt;
	end

	// Outputs come straight from the state register.
	assign wb_ack_out = s_r.ack;
	assign wb_dat_out = s_r.rd_data;
	assign serial_clock_pin_out = s_r.sclk;
	assign serial_clock_pin_oe_out = s_r.sclk_oe;
	assign fetch_from_boot_out = s_r.boot_sel;
	assign boot_jump_out = s_r.boot_jump;
	assign flash_jump_out = s_r.flash_jump;
	assign flash_return_out = s_r.flash_ret;
	assign exit_reset_req_out = s_r.exit_req;
	assign flash_pulse_timing_out = s_r.pulse_timing;
	assign security_bit_out = s_r.security;

	// A matching key write opens the window two edges later.
	a_key_match_sets: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		wr_low && wb_adr_in == OFS_BOOT_KEY && key_match ##1 !sys_rst_in |=> key_set)
		else $error("matching key write did not set key");

	// A mismatched write on a clear key leaves it clear.
	a_key_mismatch_clear: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		wr_low && wb_adr_in == OFS_BOOT_KEY && !key_match && !key_set && !s_r.key_load |=> ##1 !key_set)
		else $error("mismatched key write set key");

	// Jump with the key set enters boot.
	a_jump_enters_boot: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		s_r.exec == EXEC_FLASH && jump_to_boot_instr_in && key_set
		|=> boot_jump_out && fetch_from_boot_out)
		else $error("keyed jump did not enter boot");

	// Jump without the key stays in flash.
	a_jump_stays_flash: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		s_r.exec == EXEC_FLASH && jump_to_boot_instr_in && !key_set
		|=> flash_jump_out && !fetch_from_boot_out)
		else $error("unkeyed jump left flash");

	// Return instruction from boot resumes flash.
	a_return_to_flash: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		s_r.boot_sel && return_to_flash_instr_in |=> !fetch_from_boot_out && flash_return_out)
		else $error("return did not reach flash");

	// High voltage during reset forces boot at release.
	a_forced_boot_entry: assert property (@(posedge ref_clk_in)
		sys_rst_in && forced_boot_hv_in |=> fetch_from_boot_out && s_r.exec == EXEC_FORCED)
		else $error("forced entry did not select boot");

	// Plain reset with flex set starts in flash.
	a_plain_flash_start: assert property (@(posedge ref_clk_in)
		sys_rst_in && !forced_boot_hv_in && flash_execute_opt_in |=> !fetch_from_boot_out)
		else $error("plain reset did not start in flash");

	// Security holds unless an erase clears it.
	a_security_sticky: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		!sys_rst_in && security_bit_out && !mass_erase_in && !user_isp_sec_clear_in |=> security_bit_out)
		else $error("security bit cleared without erase");

	// Load clock drives the serial pin under high voltage; the reset edge itself clears the enable.
	a_load_clock_drive: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		!sys_rst_in && forced_boot_hv_in |=> serial_clock_pin_oe_out)
		else $error("serial pin not driven under high voltage");

	// Without high voltage the serial pin is released and the clock rests low.
	a_load_clock_off: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		!sys_rst_in && !forced_boot_hv_in |=> !serial_clock_pin_oe_out && !serial_clock_pin_out)
		else $error("serial pin driven without high voltage");

	// Each instruction tick under high voltage flips the load clock.
	a_load_clock_toggle: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		!sys_rst_in && forced_boot_hv_in && s_r.tick |=> serial_clock_pin_out != $past(serial_clock_pin_out))
		else $error("load clock did not toggle on tick");

	// An erase without a program event clears the security bit.
	a_security_erase: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		!sys_rst_in && !security_program_in && (mass_erase_in || user_isp_sec_clear_in) |=> !security_bit_out)
		else $error("erase did not clear security bit");

	// An exit write gives exactly one request pulse.
	a_exit_pulse: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		wr_low && wb_adr_in == OFS_CONTROL && wb_dat_in[CT_EXIT] |=> exit_reset_req_out ##1 !exit_reset_req_out)
		else $error("exit request was not a single pulse");

	// Timing register reads zero in its top bit.
	a_timing_msb_zero: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		wb_cyc_in && wb_stb_in && !wb_we_in && !s_r.ack && wb_adr_in == OFS_PULSE_TIMING
		|=> wb_ack_out && !wb_dat_out[7])
		else $error("timing register top bit not zero");

endmodule

// >>> verif/hv_programmer.sv
`timescale 1ns/1ns
module hv_programmer
	import boot_key_pkg::*;
(
	// Clock.
	input wire logic ref_clk_in,
	// Request from the bench.
	input wire logic start_in,
	// Programmer drive.
	output logic rst_out,
	output logic hv_out,
	output logic pin_out,
	output logic busy_out
);
	// The data source stays disconnected, so the pin level itself is low.
	initial
	begin
		rst_out = 1'b0;
		hv_out = 1'b0;
		pin_out = 1'b0;
		busy_out = 1'b0;
	end

	// Forced entry: reset first, high voltage once stable, release, then hold longer than needed.
	always @(posedge ref_clk_in)
	begin
		if (start_in && !busy_out)
		begin
			busy_out <= 1'b1;
			rst_out <= 1'b1;
			repeat (4) @(posedge ref_clk_in);
			hv_out <= 1'b1;
			repeat (4) @(posedge ref_clk_in);
			rst_out <= 1'b0;
			repeat (4 * INSTR_DIV_CYCLES) @(posedge ref_clk_in);
			hv_out <= 1'b0;
			busy_out <= 1'b0;
		end
	end
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ns
module testbench;
	import boot_key_pkg::*;

	logic ref_clk = 1'b0;
	logic bench_rst = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0;
	logic [4:0] ev = 5'h00;
	logic emu = 1'b0;
	logic bkpt = 1'b0;
	logic flex = 1'b1;
	logic sec_opt = 1'b0;
	logic start = 1'b0;
	logic prog_rst, hv, pin, busy;
	logic [31:0] wb_dat_out, rdata;
	logic wb_ack_out, serial_clock_pin_out, serial_clock_pin_oe_out, fetch_from_boot_out;
	logic boot_jump_out, flash_jump_out, flash_return_out, exit_reset_req_out, security_bit_out;
	logic [7:0] flash_pulse_timing_out;
	logic sclk_prev = 1'b0;
	int errors = 0;
	int cmp_count = 0;
	int n_bjump = 0;
	int n_fjump = 0;
	int n_fret = 0;
	int n_exit = 0;
	int n_sclk = 0;
	int a;

	always #25 ref_clk = ~ref_clk;

	boot_entry_ctrl i_boot_entry_ctrl (.ref_clk_in(ref_clk), .sys_rst_in(bench_rst | prog_rst),
		.wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
		.wb_dat_in(wb_dat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
		.jump_to_boot_instr_in(ev[0]), .return_to_flash_instr_in(ev[1]), .emulation_mode_in(emu),
		.breakpoint_in(bkpt), .flash_execute_opt_in(flex), .security_opt_in(sec_opt),
		.security_program_in(ev[2]), .mass_erase_in(ev[3]), .user_isp_sec_clear_in(ev[4]),
		.forced_boot_pin_in(pin), .forced_boot_hv_in(hv), .serial_clock_pin_out(serial_clock_pin_out),
		.serial_clock_pin_oe_out(serial_clock_pin_oe_out), .fetch_from_boot_out(fetch_from_boot_out),
		.boot_jump_out(boot_jump_out), .flash_jump_out(flash_jump_out), .flash_return_out(flash_return_out),
		.exit_reset_req_out(exit_reset_req_out), .flash_pulse_timing_out(flash_pulse_timing_out),
		.security_bit_out(security_bit_out));

	hv_programmer i_hv_programmer (.ref_clk_in(ref_clk), .start_in(start), .rst_out(prog_rst), .hv_out(hv),
		.pin_out(pin), .busy_out(busy));

	// One-cycle pulses are counted here so no test can miss one between its own waits.
	always @(posedge ref_clk)
	begin
		if (boot_jump_out === 1'b1)
			n_bjump++;
		if (flash_jump_out === 1'b1)
			n_fjump++;
		if (flash_return_out === 1'b1)
			n_fret++;
		if (exit_reset_req_out === 1'b1)
			n_exit++;
		if (serial_clock_pin_out !== sclk_prev)
			n_sclk++;
		sclk_prev = serial_clock_pin_out;
	end

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic single cycle; the request holds until ack is sampled high, read data taken at that edge.
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_sel <= 4'h1;
		wb_adr <= adr;
		wb_dat <= dat;
		@(posedge ref_clk);
		while (wb_ack_out !== 1'b1)
		begin
			n++;
			if (n > 16)
			begin
				chk(32'(wb_ack_out), 32'h1);
				give_verdict();
			end
			@(posedge ref_clk);
		end
		rdata = wb_dat_out;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_sel <= 4'h0;
	endtask

	task automatic pulse(input int b);
		@(posedge ref_clk);
		ev[b] <= 1'b1;
		@(posedge ref_clk);
		ev[b] <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic key_is(input logic exp);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk(32'(rdata[ST_KEY_SET]), 32'(exp));
	endtask

	// Main sequence; key window timings allow for the unknown tick phase at the load.
	initial
	begin
		tick(16);
		bench_rst <= 1'b0;
		wb(1'b0, OFS_PULSE_TIMING, 32'h0);
		chk(rdata, 32'(PULSE_TIMING_RST));
		chk(32'(fetch_from_boot_out), 32'h0);
		wb(1'b0, OFS_BOOT_KEY, 32'h0);
		chk(rdata, 32'h0);
		wb(1'b0, 8'h10, 32'h0);
		chk(rdata, 32'h0);
		for (int i = 0; i < 19; i++)
		begin
			wb(1'b1, OFS_PULSE_TIMING, {24'h0, TIMING_CODES[i]});
			wb(1'b0, OFS_STATUS, 32'h0);
			chk(32'(rdata[ST_CODE_LISTED]), 32'h1);
			chk(32'(flash_pulse_timing_out), 32'(TIMING_CODES[i]));
		end
		wb(1'b1, OFS_PULSE_TIMING, 32'hff);
		wb(1'b0, OFS_PULSE_TIMING, 32'h0);
		chk(rdata, 32'h7f);
		wb(1'b1, OFS_BOOT_KEY, 32'h9c);
		key_is(1'b0);
		pulse(0);
		chk(32'(n_fjump), 32'h1);
		chk(32'(fetch_from_boot_out), 32'h0);
		wb(1'b1, OFS_BOOT_KEY, 32'h9b);
		key_is(1'b1);
		pulse(0);
		chk(32'(n_bjump), 32'h1);
		chk(32'(fetch_from_boot_out), 32'h1);
		pulse(1);
		chk(32'(n_fret), 32'h1);
		chk(32'(fetch_from_boot_out), 32'h0);
		tick(200);
		wb(1'b1, OFS_BOOT_KEY, 32'h98);
		tick(125);
		key_is(1'b1);
		tick(40);
		key_is(1'b0);
		pulse(0);
		chk(32'(n_fjump), 32'h2);
		wb(1'b1, OFS_BOOT_KEY, 32'h99);
		tick(100);
		wb(1'b1, OFS_BOOT_KEY, 32'h9a);
		tick(100);
		key_is(1'b1);
		tick(80);
		key_is(1'b0);
		emu <= 1'b1;
		wb(1'b1, OFS_BOOT_KEY, 32'h98);
		bkpt <= 1'b1;
		tick(300);
		key_is(1'b1);
		bkpt <= 1'b0;
		tick(200);
		key_is(1'b0);
		wb(1'b1, OFS_CONTROL, 32'h0);
		wb(1'b1, OFS_CONTROL, 32'h1);
		tick(3);
		chk(32'(n_exit), 32'h1);
		pulse(2);
		chk(32'(security_bit_out), 32'h1);
		pulse(3);
		chk(32'(security_bit_out), 32'h0);
		pulse(2);
		pulse(4);
		chk(32'(security_bit_out), 32'h0);
		sec_opt <= 1'b1;
		start <= 1'b1;
		tick(1);
		start <= 1'b0;
		tick(20);
		chk(32'(fetch_from_boot_out), 32'h1);
		chk(32'(serial_clock_pin_oe_out), 32'h1);
		chk(32'(security_bit_out), 32'h1);
		// The timing value goes in first, while boot code runs and flash stays untouched.
		wb(1'b1, OFS_PULSE_TIMING, {24'h0, TIMING_CODES[18]});
		wb(1'b0, OFS_STATUS, 32'h0);
		chk(32'(flash_pulse_timing_out), 32'(TIMING_CODES[18]));
		chk(32'(rdata[ST_IN_BOOT]), 32'h1);
		chk(32'(rdata[6:4]), 32'h7);
		chk(32'(rdata[ST_FORCED_PIN]), 32'h1);
		a = n_sclk;
		tick(60);
		chk(32'(n_sclk - a), 32'h3);
		a = 0;
		while (busy === 1'b1)
		begin
			a++;
			if (a > 200)
			begin
				chk(32'(busy), 32'h0);
				give_verdict();
			end
			tick(1);
		end
		tick(3);
		chk(32'(serial_clock_pin_oe_out), 32'h0);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk(32'(rdata[ST_FORCED_PIN]), 32'h0);
		pulse(1);
		chk(32'(fetch_from_boot_out), 32'h0);
		// Enter boot again so that the plain reset below has something to undo.
		wb(1'b1, OFS_BOOT_KEY, 32'h98);
		pulse(0);
		chk(32'(fetch_from_boot_out), 32'h1);
		bench_rst <= 1'b1;
		tick(2);
		bench_rst <= 1'b0;
		tick(2);
		chk(32'(fetch_from_boot_out), 32'h0);
		chk(32'(security_bit_out), 32'h1);
		// A cleared flash-execute bit sends a plain reset to boot instead.
		flex <= 1'b0;
		bench_rst <= 1'b1;
		tick(2);
		bench_rst <= 1'b0;
		tick(2);
		chk(32'(fetch_from_boot_out), 32'h1);
		give_verdict();
	end
endmodule
